// [src/conv_ctrl_regs.svh]
`ifndef CONV_CTRL_REGS_SVH
`define CONV_CTRL_REGS_SVH
// register offsets (byte addresses on the register port)
`define OFS_DISABLE 8'h17
`define OFS_RESULT 8'h19
`define OFS_CHANNEL 8'h1b
`define OFS_CONTROL 8'h1c
`define OFS_TRIGGER 8'h1d
// control register fields
`define BIT_ON 7
`define BIT_GO 6
`define BIT_AUTO 5
`define BIT_DONE 4
`define BIT_IRQ_ON 3
// reset values
`define RST_BYTE 8'h00
// conversion lengths in converter clock cycles
`define FIRST_CYCLES 5'd25
`define NORMAL_CYCLES 5'd13
`endif

// [src/conv_ctrl_pkg.sv]
package conv_ctrl_pkg;
    typedef enum logic [2:0] {
        SRC_FREE, SRC_COMPARATOR, SRC_EXT_INT0, SRC_COMPARE_A,
        SRC_OVERFLOW, SRC_COMPARE_B, SRC_PIN_CHANGE, SRC_CAPTURE
    } trigger_src_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        logic comparator;
        logic extInt0;
        logic compareA;
        logic overflow;
        logic compareB;
        logic pinChange;
        logic capture;
    } trigger_in_t;
endpackage

// [src/sar_core.sv]
`timescale 1ns/1ps
`include "conv_ctrl_regs.svh"
// successive approximation core model: counts converter clock ticks, then
// returns the quantised code of the selected input
module sar_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // control
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic first,
    input wire logic [1:0] channel,
    input wire logic [7:0] sample0,
    input wire logic [7:0] sample1,
    input wire logic [7:0] sample2,
    input wire logic [7:0] sample3,
    // results
    output logic busy,
    output logic lastCycle,
    output logic done,
    output logic [7:0] code
);
    logic [4:0] left;
    logic [1:0] held;

    assign lastCycle = busy && (left == 5'd1);

    // cycle counter, advances on converter clock ticks
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
            left <= 5'd0;
            done <= 1'b0;
            held <= 2'd0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start && !busy) begin
                busy <= 1'b1;
                held <= channel;
                left <= first ? `FIRST_CYCLES : `NORMAL_CYCLES;
            end else if (busy && tick) begin
                left <= left - 5'd1;
                if (left == 5'd1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    // code register, samples are Vin*256/Vref already saturated at 0xff
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            code <= `RST_BYTE;
        end else if (busy && tick && left == 5'd1 && !abort) begin
            case (held)
                2'd0: code <= sample0;
                2'd1: code <= sample1;
                2'd2: code <= sample2;
                default: code <= sample3;
            endcase
        end
    end
endmodule

// [src/analog_conversion_control.sv]
`timescale 1ns/1ps
`include "conv_ctrl_regs.svh"
module analog_conversion_control (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire conv_ctrl_pkg::reg_req_t req,
    output logic [7:0] rdata,
    // analog inputs, already quantised per pin
    input wire logic [7:0] sample0,
    input wire logic [7:0] sample1,
    input wire logic [7:0] sample2,
    input wire logic [7:0] sample3,
    // trigger flags from other peripherals (same clock)
    input wire conv_ctrl_pkg::trigger_in_t trig,
    // interrupt vector acknowledge and request
    input wire logic vectorAck,
    output logic irqRequest,
    // digital pin path
    input wire logic [3:0] pinRaw,
    output logic [3:0] pinRead,
    output logic [3:0] digitalInputOff
);
    import conv_ctrl_pkg::*;

    logic [1:0] channelCode;
    logic [1:0] activeChannel;
    logic converterOn;
    logic goPending;
    logic autoTriggerOn;
    logic doneFlag;
    logic doneIrqOn;
    logic [2:0] divider;
    trigger_src_t triggerSource;
    logic [3:0] digitalInputOffBits;
    logic [7:0] result;
    logic firstPending;
    logic [6:0] prescale;
    logic tick;
    logic selectedFlag;
    logic lastFlag;
    logic trigEdge;
    logic busy;
    logic lastCycle;
    logic coreDone;
    logic [7:0] coreCode;
    logic ctlWrite;
    // control qualifiers shared by several processes
    logic ctlGoWrite;
    logic ctlOffWrite;
    logic startNow;
    logic coreAbort;
    logic goBit;
    logic doneClear;
    logic [7:0] pinSync1;
    logic [3:0] pinSync2;

    // division mask: tick when the low bits of the counter are all ones
    // codes zero and one both give a divide by two
    function automatic logic [6:0] divMask(input logic [2:0] code);
        case (code)
            3'd0, 3'd1: divMask = 7'h01;
            3'd2: divMask = 7'h03;
            3'd3: divMask = 7'h07;
            3'd4: divMask = 7'h0f;
            3'd5: divMask = 7'h1f;
            3'd6: divMask = 7'h3f;
            default: divMask = 7'h7f;
        endcase
    endfunction

    // source decode
    // flag lookup for a trigger code; code zero reads the done flag, while the
    // restart path uses the core done strobe and the edge path skips code zero
    function automatic logic srcFlag(input trigger_src_t s, input trigger_in_t t,
                                     input logic done);
        case (s)
            SRC_FREE: srcFlag = done;
            SRC_COMPARATOR: srcFlag = t.comparator;
            SRC_EXT_INT0: srcFlag = t.extInt0;
            SRC_COMPARE_A: srcFlag = t.compareA;
            SRC_OVERFLOW: srcFlag = t.overflow;
            SRC_COMPARE_B: srcFlag = t.compareB;
            SRC_PIN_CHANGE: srcFlag = t.pinChange;
            default: srcFlag = t.capture;
        endcase
    endfunction

    // register decode shared by every write path
    function automatic logic regHit(input reg_req_t r, input logic [7:0] ofs);
        regHit = r.wr && (r.addr == ofs);
    endfunction

    // control write qualifiers, decoded once and reused below
    assign ctlWrite = regHit(req, `OFS_CONTROL);
    assign ctlGoWrite = ctlWrite && req.wdata[`BIT_GO];
    // a write with the enable bit low is the abort request
    assign ctlOffWrite = ctlWrite && !req.wdata[`BIT_ON];
    // write-one clear of the done flag
    assign doneClear = ctlWrite && req.wdata[`BIT_DONE];

    // prescaler divide
    // counter held at zero while off, so the first converter edge after
    // enabling always comes a whole divide period later
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prescale <= 7'h00;
        end else if (!converterOn) begin
            prescale <= 7'h00;
        end else begin
            prescale <= prescale + 7'h01;
        end
    end
    // tick marks a converter clock rising edge; a divider change mid-conversion
    // only moves the next edge, there is no real clock that could glitch
    assign tick = converterOn && ((prescale & divMask(divider)) == divMask(divider));

    // channel tracking, locked while converting until the last converter cycle
    // the core latches its own copy at start; this register only feeds it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            activeChannel <= 2'd0;
        end else if (!busy || lastCycle) begin
            activeChannel <= channelCode;
        end
    end

    // edge detect on selected flag
    // lastFlag follows whichever source is selected, so switching onto a set
    // source is seen as an edge; reset value matches the idle flag level
    assign selectedFlag = srcFlag(triggerSource, trig, doneFlag);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lastFlag <= 1'b0;
        end else begin
            lastFlag <= selectedFlag;
        end
    end
    // free running handled by restart path, never by this edge
    assign trigEdge = autoTriggerOn && converterOn && triggerSource != SRC_FREE
                      && selectedFlag && !lastFlag;

    // go bit seen by software: pending start or running core
    assign goBit = busy || goPending;
    // start strobe, one system clock wide on a converter edge
    assign startNow = goPending && tick;
    // the core stops at once while the converter is off
    assign coreAbort = !converterOn;

    // start request held until the next converter edge
    // trigger edges that arrive while busy are dropped, not queued
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            goPending <= 1'b0;
        end else if (ctlOffWrite) begin
            goPending <= 1'b0;
        end else if (ctlGoWrite && !busy) begin
            goPending <= 1'b1;
        end else if (trigEdge && !busy) begin
            goPending <= 1'b1;
        end else if (coreDone && autoTriggerOn && triggerSource == SRC_FREE) begin
            goPending <= 1'b1;
        end else if (startNow) begin
            goPending <= 1'b0;
        end
    end

    // first conversion marker
    // set again on every off to on write, so a re-enabled converter
    // always spends the long initialisation conversion first
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            firstPending <= 1'b1;
        end else if (ctlWrite && req.wdata[`BIT_ON] && !converterOn) begin
            firstPending <= 1'b1;
        end else if (startNow) begin
            firstPending <= 1'b0;
        end
    end

    // analog core
    // the core keeps the cycle count; this block only schedules and records
    sar_core core (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick(tick),
        .start(startNow),
        .abort(coreAbort),
        .first(firstPending),
        .channel(activeChannel),
        .sample0(sample0),
        .sample1(sample1),
        .sample2(sample2),
        .sample3(sample3),
        .busy(busy),
        .lastCycle(lastCycle),
        .done(coreDone),
        .code(coreCode)
    );

    // result capture
    // result and flag move on the same edge, a read never sees one alone
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            result <= `RST_BYTE;
        end else if (coreDone) begin
            result <= coreCode;
        end
    end

    // done flag, set wins over clear
    // a clear landing on the completing edge loses, so no result goes unseen
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            doneFlag <= 1'b0;
        end else if (coreDone) begin
            doneFlag <= 1'b1;
        end else if (vectorAck || doneClear) begin
            doneFlag <= 1'b0;
        end
    end

    // interrupt request
    // kept combinational so a clear drops the request in the same cycle
    assign irqRequest = doneFlag && doneIrqOn;

    // control register writable fields
    // fields load together; go and done bits are strobes, never stored here
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            converterOn <= 1'b0;
            autoTriggerOn <= 1'b0;
            doneIrqOn <= 1'b0;
            divider <= 3'd0;
        end else if (ctlWrite) begin
            converterOn <= req.wdata[`BIT_ON];
            autoTriggerOn <= req.wdata[`BIT_AUTO];
            doneIrqOn <= req.wdata[`BIT_IRQ_ON];
            divider <= req.wdata[2:0];
        end
    end

    // only low bits stored, upper bits of each register are dropped here
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            channelCode <= 2'h0;
        end else if (regHit(req, `OFS_CHANNEL)) begin
            channelCode <= req.wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            triggerSource <= SRC_FREE;
        end else if (regHit(req, `OFS_TRIGGER)) begin
            triggerSource <= trigger_src_t'(req.wdata[2:0]);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            digitalInputOffBits <= 4'h0;
        end else if (regHit(req, `OFS_DISABLE)) begin
            digitalInputOffBits <= req.wdata[3:0];
        end
    end

    // pins are asynchronous, two flops before use
    // pinSync1 is read by the second stage only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pinSync1 <= 8'h00;
            pinSync2 <= 4'h0;
        end else begin
            pinSync1 <= {4'h0, pinRaw};
            pinSync2 <= pinSync1[3:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pinRead <= 4'h0;
        end else begin
            pinRead <= pinSync2 & ~digitalInputOffBits;
        end
    end
    // the disable bits also leave the block to switch off the input buffers
    assign digitalInputOff = digitalInputOffBits;

    // read data, registered, one cycle after the strobe; unmapped reads zero
    // reads have no side effect, so polling the go bit is safe
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= `RST_BYTE;
        end else if (req.rd) begin
            case (req.addr)
                `OFS_RESULT: rdata <= result;
                `OFS_CHANNEL: rdata <= {6'h00, channelCode};
                `OFS_DISABLE: rdata <= {4'h0, digitalInputOffBits};
                `OFS_CONTROL: rdata <= {converterOn, goBit, autoTriggerOn,
                                        doneFlag, doneIrqOn, divider};
                `OFS_TRIGGER: rdata <= {5'h00, triggerSource};
                default: rdata <= `RST_BYTE;
            endcase
        end else begin
            rdata <= `RST_BYTE;
        end
    end
endmodule

// [bench/analog_conversion_control_sva.sv]
`timescale 1ns/1ps
`include "conv_ctrl_regs.svh"
// port checks: read answers, pin masking, interrupt request
module analog_conversion_control_sva (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire conv_ctrl_pkg::reg_req_t req,
    input wire logic [7:0] rdata,
    // interrupt and pins
    input wire logic vectorAck,
    input wire logic irqRequest,
    input wire logic [3:0] pinRead,
    input wire logic [3:0] digitalInputOff
);
    import conv_ctrl_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    a_rdata_quiet: assert property (!$past(req.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside an answer");
    a_chan_reserved: assert property ($past(req.rd && req.addr == `OFS_CHANNEL)
        |-> rdata[7:2] == 6'h00) else $error("channel reserved bits set");
    a_trig_reserved: assert property ($past(req.rd && req.addr == `OFS_TRIGGER)
        |-> rdata[7:3] == 5'h00) else $error("trigger reserved bits set");
    a_dis_reserved: assert property ($past(req.rd && req.addr == `OFS_DISABLE)
        |-> rdata[7:4] == 4'h0) else $error("disable reserved bits set");
    a_dis_follow: assert property (req.wr && req.addr == `OFS_DISABLE
        |=> digitalInputOff == $past(req.wdata[3:0])) else $error("disable bits wrong");
    a_pin_masked: assert property ((pinRead & digitalInputOff
        & $past(digitalInputOff) & $past(digitalInputOff, 2)) == 4'h0)
        else $error("disabled pin reads one");
    a_irq_track: assert property ($past(req.rd && req.addr == `OFS_CONTROL)
        |-> (rdata[`BIT_DONE] && rdata[`BIT_IRQ_ON]) == $past(irqRequest))
        else $error("request disagrees with flag and enable");
    a_irq_mask: assert property (req.wr && req.addr == `OFS_CONTROL
        && !req.wdata[`BIT_IRQ_ON] |=> !irqRequest) else $error("request while masked");
    // main scenarios
    cover property ($rose(irqRequest));
    cover property (vectorAck && irqRequest);
    cover property (pinRead != 4'h0 ##1 digitalInputOff != 4'h0);
endmodule
bind analog_conversion_control analog_conversion_control_sva analog_conversion_control_sva_i (
    .sys_clk(sys_clk), .resetn(resetn), .req(req), .rdata(rdata), .vectorAck(vectorAck),
    .irqRequest(irqRequest), .pinRead(pinRead), .digitalInputOff(digitalInputOff)
);

// [bench/analog_conversion_control_tb_top.sv]
`timescale 1ns/1ps
`include "conv_ctrl_regs.svh"
// register-port bench: call sequences with expected answers
module analog_conversion_control_tb_top;
    import conv_ctrl_pkg::*;
    localparam logic [7:0] CTL = `OFS_CONTROL, CHN = `OFS_CHANNEL;
    localparam logic [7:0] TRG = `OFS_TRIGGER, RES = `OFS_RESULT, DIS = `OFS_DISABLE;
    // stimulus and observed signals
    logic sysClk = 1'b0;
    logic resetn = 1'b0;
    reg_req_t req = '0;
    trigger_in_t trig = '0;
    logic vectorAck = 1'b0;
    logic [3:0] pinRaw = 4'hF;
    logic [7:0] smp [4] = '{8'h00, 8'h5A, 8'hA5, 8'hFF};
    logic [7:0] rdata, got;
    logic irqRequest;
    logic [3:0] pinRead, digitalInputOff;
    int errorCnt = 0;
    int nTests = 0;
    int took;
    // sweep table; 0x20 is unmapped
    logic [7:0] adr [5] = '{DIS, RES, CHN, TRG, 8'h20};
    logic [7:0] msk [5] = '{8'h0F, 8'h00, 8'h03, 8'h07, 8'h00};
    analog_conversion_control analog_conversion_control_i (
        .sys_clk(sysClk), .resetn(resetn), .req(req), .rdata(rdata),
        .sample0(smp[0]), .sample1(smp[1]), .sample2(smp[2]), .sample3(smp[3]),
        .trig(trig), .vectorAck(vectorAck), .irqRequest(irqRequest),
        .pinRaw(pinRaw), .pinRead(pinRead), .digitalInputOff(digitalInputOff)
    );
    // 200 MHz clock
    initial begin
        forever #2.5 sysClk = ~sysClk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        nTests++;
        if (g !== e) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one-cycle strobes; return just after the taking edge so outputs settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sysClk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge sysClk) req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sysClk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sysClk) req.rd <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(got, e);
    endtask
    // bounded poll of a control bit, elapsed cycles left in took
    task automatic wt(input int b, input logic v);
        time t0;
        int n;
        t0 = $time;
        n = 0;
        rd(CTL);
        while (got[b] !== v && n < 3000) begin
            rd(CTL);
            n++;
        end
        took = int'(($time - t0) / 5);
        chk({7'h00, got[b]}, {7'h00, v});
    endtask
    function automatic int divOf(input int c);
        return (c < 2) ? 2 : (1 << c);
    endfunction
    // start may wait up to one tick, polling adds a few cycles
    task automatic dur(input int t, input int n, input int d);
        chk({7'h00, t >= (n - 1) * d && t <= (n + 1) * d + 8}, 8'h01);
    endtask
    task automatic closeOut();
        if (errorCnt == 0 && nTests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // watchdog far past the expected 4600 or so cycles
    initial begin
        #200000;
        errorCnt++;
        closeOut();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge sysClk);
        resetn <= 1'b1;
        for (int i = 0; i < 5; i++) rc(adr[i], 8'h00);
        rc(CTL, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(adr[i], 8'hFF);
            rc(adr[i], msk[i]);
        end
        wr(DIS, 8'h05);
        repeat (6) @(posedge sysClk);
        #1 chk({4'h0, pinRead}, 8'h0A);
        chk({4'h0, digitalInputOff}, 8'h05);
        // first conversion after enabling is the long one
        wr(CHN, 8'h00);
        wr(CTL, 8'hC0);
        wt(`BIT_GO, 1'b0);
        dur(took, 25, 2);
        rc(RES, smp[0]);
        rc(CTL, 8'h90);
        // all divider codes; channel rewritten mid-conversion must wait
        for (int c = 0; c < 8; c++) begin
            wr(CHN, 8'(c % 4));
            wr(CTL, 8'(8'hD0 | c));
            repeat (2 * divOf(c)) @(posedge sysClk);
            wr(CHN, 8'((c + 1) % 4));
            wt(`BIT_GO, 1'b0);
            dur(took + 2 * divOf(c) + 2, 13, divOf(c));
            rc(RES, smp[c % 4]);
            rc(CTL, 8'(8'h90 | c));
        end
        // turning off mid-conversion aborts it
        wr(CTL, 8'hD7);
        repeat (300) @(posedge sysClk);
        wr(CTL, 8'h07);
        rc(CTL, 8'h07);
        // request follows flag and enable; vector clears the flag
        wr(CTL, 8'hC8);
        wt(`BIT_GO, 1'b0);
        chk({7'h00, irqRequest}, 8'h01);
        wr(CTL, 8'h80);
        chk({7'h00, irqRequest}, 8'h00);
        wr(CTL, 8'h88);
        @(posedge sysClk) vectorAck <= 1'b1;
        @(posedge sysClk) vectorAck <= 1'b0;
        #1 chk({7'h00, irqRequest}, 8'h00);
        rc(CTL, 8'h88);
        // each source from code 1 to 7: switching onto a set flag is an edge
        wr(CTL, 8'hA0);
        for (int k = 1; k < 8; k++) begin
            wr(TRG, 8'h00);
            rc(CTL, (k == 1) ? 8'hA0 : 8'hB0);
            wr(CTL, 8'hB0);
            @(posedge sysClk) trig <= trigger_in_t'(7'(1 << (7 - k)));
            wr(TRG, 8'(k));
            wt(`BIT_DONE, 1'b1);
            @(posedge sysClk) trig <= '0;
        end
        // auto trigger off: source ignored, write-one cleared the flag
        wr(CTL, 8'h90);
        wr(TRG, 8'h01);
        @(posedge sysClk) trig <= trigger_in_t'(7'h40);
        repeat (80) @(posedge sysClk);
        rc(CTL, 8'h80);
        // free running restarts without another go write
        wr(TRG, 8'h00);
        wr(CTL, 8'hE0);
        wt(`BIT_DONE, 1'b1);
        wr(CTL, 8'hB0);
        wt(`BIT_DONE, 1'b1);
        wr(CTL, 8'h00);
        closeOut();
    end
endmodule
